/* File: master_model.sv */
// far-side model: frame sender, reply collector and reference table
`timescale 1ns/100ps
`default_nettype none
module master_model #(
  parameter int POST_BREAK_WAIT = 16,
  parameter int BCAST_DELAY = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic long_break,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic slow,
  input wire logic stall,
  // reference table
  input wire serial_table_access_pkg::tbl_req_t tbl_req,
  output logic [7:0] tbl_rdata
);
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  logic [9:0] iq[$];
  logic [7:0] lf = 8'h5B;
  logic busy = 1'b0;
  function automatic logic [7:0] tbyte(input logic [15:0] off, input logic [9:0] idx);
    return (off[7:0] + idx[7:0]) ^ 8'h3C;
  endfunction
  // read data only while a read is requested, noise otherwise
  assign tbl_rdata = (tbl_req.en && !tbl_req.we) ? tbyte(tbl_req.offset, tbl_req.index) : ~lf;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    long_break = 1'b0;
    tx_ready = 1'b0;
  end
  always @(posedge ref_clk) begin
    lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    tx_ready <= rst_n && !stall && (!slow || lf[0]);
    if (!busy) rx_data <= ~rx_data;
    if (tx_valid && tx_ready) rq.push_back(tx_data);
    if (tbl_req.en && tbl_req.we) begin
      wq.push_back(tbl_req.wdata);
      iq.push_back(tbl_req.index);
    end
  end
  // one byte per clock, back to back
  task automatic send(input logic [7:0] fr[$]);
    busy = 1'b1;
    foreach (fr[i]) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= fr[i];
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    busy = 1'b0;
  endtask
  task automatic brk();
    @(posedge ref_clk);
    long_break <= 1'b1;
    @(posedge ref_clk);
    long_break <= 1'b0;
    repeat (POST_BREAK_WAIT) @(posedge ref_clk);
  endtask
  task automatic bcast_wait();
    repeat (BCAST_DELAY) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* File: serial_table_access_consts.svh */
// framing, field position and limit constants for the table access slave
`ifndef SERIAL_TABLE_ACCESS_CONSTS_SVH
`define SERIAL_TABLE_ACCESS_CONSTS_SVH
`define SOM 8'h1B
`define TYPE_REQ 8'h58
`define TYPE_BUF 8'h54
`define EOB 8'h17
`define ZERO_BYTE 8'h00
`define ID_BCAST 64'hFFFF_FFFF_FFFF_FFFF
`define ID_NULL 64'h0000_0000_0000_0000
`define REQ_ATTACH 8'h00
`define REQ_READ 8'h01
`define REQ_WRITE 8'h02
`define RESP_BIT 8'h80
`define SEG_WORD 8'h08
`define SEG_BITMODE_BIT 6
`define ERR_NONE 8'h00
`define ERR_REQ 8'h01
`define ERR_LEN 8'h02
`define MAX_DATA 11'd1000
`define SHORT_MAX 11'd2
`define REQ_LEN 11'd24
`define BUF_OVH 11'd8
`define RESP_HDR 11'd9
`define RESP_TRL 11'd6
`define P_SOM 11'd1
`define P_TYPE 11'd2
`define P_ID_LO 11'd3
`define P_ID_HI 11'd10
`define P_CODE 11'd11
`define P_SEG 11'd12
`define P_OFF0 11'd13
`define P_OFF1 11'd14
`define P_LEN0 11'd15
`define P_LEN1 11'd16
`define P_D0 11'd17
`define P_D1 11'd18
`define P_EOB 11'd19
`define P_NTYPE 11'd20
`define P_NLEN0 11'd21
`define P_NLEN1 11'd22
`define R_CODE 11'd3
`define R_STW0 11'd4
`define R_STW1 11'd5
`define R_MAJ 11'd6
`define R_CNT0 11'd8
`define R_CNT1 11'd9
`define FIFO_W 8
`define FIFO_DEPTH 8
`endif

/* File: serial_table_access_pkg.sv */
// types shared by the table access slave
package serial_table_access_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BUF, ST_COMMIT, ST_TX} slave_st_t;
  typedef enum logic [1:0] {TX_RESP, TX_ATTACH, TX_INTERM} tx_kind_t;
  typedef struct packed {
    logic en;
    logic we;
    logic [7:0] seg;
    logic [15:0] offset;
    logic [9:0] index;
    logic [7:0] wdata;
  } tbl_req_t;
  typedef struct packed {
    slave_st_t st;
    tx_kind_t kind;
    logic [10:0] ridx;
    logic [7:0] racc;
    logic [63:0] id;
    logic [7:0] code;
    logic [7:0] seg;
    logic [15:0] off;
    logic [15:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] ntype;
    logic [15:0] nlen;
    logic bad;
    logic [10:0] nbytes;
    logic [7:0] err;
    logic session;
    logic bcast;
    logic [10:0] tidx;
    logic [7:0] tacc;
    logic rd_wait;
    tbl_req_t tbl;
  } slave_state_t;
endpackage

/* File: serial_table_access_slave.sv */
// serial table access slave: attach, table read and table write handling
`include "serial_table_access_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// replaceable block check step
module block_check_unit (
  input wire logic [7:0] acc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] acc_out
);
  assign acc_out = {acc_in[6:0], acc_in[7]} ^ data_in;
endmodule

module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [W-1:0] head;
    logic full;
    logic nonempty;
  } fifo_state_t;
  fifo_state_t f_r, f_nxt;
  logic wr, rd;
  assign wr = in_valid && !f_r.full;
  assign rd = out_ready && f_r.nonempty;
  assign in_ready = !f_r.full;
  assign out_valid = f_r.nonempty;
  assign out_data = f_r.head;
  always_comb begin
    f_nxt = f_r;
    if (wr) begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = f_r.wp + AW'(1);
    end
    if (rd) begin
      f_nxt.rp = f_r.rp + AW'(1);
    end
    f_nxt.cnt = f_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    f_nxt.full = f_nxt.cnt == (AW+1)'(DEPTH);
    f_nxt.nonempty = f_nxt.cnt != '0;
    f_nxt.head = f_nxt.mem[f_nxt.rp];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end
endmodule

module serial_table_access_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // station setup
  input wire logic [63:0] own_id,
  input wire logic p2p_mode,
  input wire logic [15:0] ctl_status,
  // link receive
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic long_break,
  // link transmit
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // reference table
  output serial_table_access_pkg::tbl_req_t tbl_req,
  input wire logic [7:0] tbl_rdata,
  // status
  output logic session_active
);
  serial_table_access_pkg::slave_state_t s_r, s_nxt;
  logic [7:0] wbuf [0:`MAX_DATA-11'd1];
  logic wb_we, push, fifo_ready, last, chk_ok, bc, me, in_data;
  logic [9:0] wb_addr;
  logic [7:0] pbyte, racc_o, tacc_o;
  logic [10:0] p, total, cnt, eobp;
  logic [16:0] nb;
  logic [2:0] sh;

  function automatic logic [16:0] data_bytes(input logic [7:0] seg, input logic [15:0] len);
    if (seg == `SEG_WORD) begin
      data_bytes = {len, 1'b0};
    end else if (seg[`SEG_BITMODE_BIT]) begin
      data_bytes = {4'h0, len[15:3]} + {16'h0000, |len[2:0]};
    end else begin
      data_bytes = {1'b0, len};
    end
  endfunction

  block_check_unit u_rx_bcc (
    .acc_in((p == `P_SOM) ? `ZERO_BYTE : s_r.racc),
    .data_in(rx_data),
    .acc_out(racc_o)
  );
  block_check_unit u_tx_bcc (
    .acc_in(s_r.tacc),
    .data_in(pbyte),
    .acc_out(tacc_o)
  );
  byte_fifo #(.W(`FIFO_W), .DEPTH(`FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data(pbyte),
    .in_ready(fifo_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  assign tbl_req = s_r.tbl;
  assign session_active = s_r.session;
  assign p = s_r.ridx + 11'd1;
  assign cnt = (s_r.kind == serial_table_access_pkg::TX_RESP) ? s_r.nbytes : 11'd0;
  assign total = (s_r.kind == serial_table_access_pkg::TX_ATTACH) ? `REQ_LEN
               : `RESP_HDR + cnt + `RESP_TRL;
  assign eobp = (s_r.kind == serial_table_access_pkg::TX_ATTACH) ? `P_EOB
              : `RESP_HDR + cnt + 11'd1;
  assign in_data = s_r.kind == serial_table_access_pkg::TX_RESP && s_r.tidx > `RESP_HDR
                && s_r.tidx <= `RESP_HDR + s_r.nbytes;
  assign sh = 3'(`P_ID_HI - s_r.tidx);
  assign nb = data_bytes(s_r.seg, s_r.len);
  assign bc = s_r.id == `ID_BCAST;
  assign me = s_r.id == own_id || (p2p_mode && s_r.id == `ID_NULL);
  assign chk_ok = rx_data == s_r.racc;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tbl.en = 1'b0;
    push = 1'b0;
    pbyte = `ZERO_BYTE;
    wb_we = 1'b0;
    wb_addr = 10'(p - `P_ID_LO);
    last = 1'b0;
    if (long_break) begin
      s_nxt.session = 1'b0;
      s_nxt.st = serial_table_access_pkg::ST_IDLE;
      s_nxt.ridx = 11'd0;
      s_nxt.rd_wait = 1'b0;
    end else begin
      unique case (s_r.st)
        serial_table_access_pkg::ST_IDLE, serial_table_access_pkg::ST_BUF: begin
          if (rx_valid) begin
            s_nxt.ridx = p;
            s_nxt.racc = racc_o;
            if (s_r.st == serial_table_access_pkg::ST_IDLE) begin
              last = p == `REQ_LEN;
              if (p >= `P_ID_LO && p <= `P_ID_HI) s_nxt.id = {s_r.id[55:0], rx_data};
              if (p == `P_CODE) s_nxt.code = rx_data;
              if (p == `P_SEG) s_nxt.seg = rx_data;
              if (p == `P_OFF0) s_nxt.off[7:0] = rx_data;
              if (p == `P_OFF1) s_nxt.off[15:8] = rx_data;
              if (p == `P_LEN0) s_nxt.len[7:0] = rx_data;
              if (p == `P_LEN1) s_nxt.len[15:8] = rx_data;
              if (p == `P_D0) s_nxt.d0 = rx_data;
              if (p == `P_D1) s_nxt.d1 = rx_data;
              if (p == `P_NTYPE) s_nxt.ntype = rx_data;
              if (p == `P_NLEN0) s_nxt.nlen[7:0] = rx_data;
              if (p == `P_NLEN1) s_nxt.nlen[15:8] = rx_data;
              if (p == `P_TYPE && rx_data != `TYPE_REQ) s_nxt.bad = 1'b1;
              if (p == `P_EOB && rx_data != `EOB) s_nxt.bad = 1'b1;
            end else begin
              last = p == s_r.nlen[10:0];
              if (p == `P_TYPE && rx_data != `TYPE_BUF) s_nxt.bad = 1'b1;
              if (p >= `P_ID_LO && p < s_r.nbytes + `P_ID_LO) wb_we = 1'b1;
              if (p == s_r.nbytes + `P_ID_LO && rx_data != `EOB) s_nxt.bad = 1'b1;
            end
            if (p == `P_SOM && rx_data != `SOM) s_nxt.ridx = 11'd0;
            if (last) begin
              s_nxt.ridx = 11'd0;
              s_nxt.bad = 1'b0;
              s_nxt.tidx = 11'd1;
              s_nxt.tacc = `ZERO_BYTE;
              s_nxt.err = `ERR_NONE;
              s_nxt.kind = serial_table_access_pkg::TX_RESP;
              if (!chk_ok) begin
                s_nxt.st = serial_table_access_pkg::ST_IDLE;
              end else if (s_r.st == serial_table_access_pkg::ST_BUF) begin
                if (s_r.bad) begin
                  s_nxt.err = `ERR_REQ;
                  s_nxt.nbytes = 11'd0;
                  s_nxt.st = s_r.bcast ? serial_table_access_pkg::ST_IDLE
                           : serial_table_access_pkg::ST_TX;
                end else begin
                  s_nxt.tidx = 11'd0;
                  s_nxt.st = serial_table_access_pkg::ST_COMMIT;
                end
              end else if (!s_r.bad && (bc || me)) begin
                s_nxt.bcast = bc;
                if (s_r.code == `REQ_ATTACH) begin
                  s_nxt.session = 1'b1;
                  if (!bc) begin
                    s_nxt.kind = serial_table_access_pkg::TX_ATTACH;
                    s_nxt.st = serial_table_access_pkg::ST_TX;
                  end
                end else if (s_r.session && s_r.code == `REQ_READ) begin
                  if (!bc) begin
                    s_nxt.st = serial_table_access_pkg::ST_TX;
                    if (nb == 17'd0 || nb > 17'(`MAX_DATA)) begin
                      s_nxt.err = `ERR_LEN;
                      s_nxt.nbytes = 11'd0;
                    end else begin
                      s_nxt.nbytes = nb[10:0];
                    end
                  end
                end else if (s_r.session && s_r.code == `REQ_WRITE) begin
                  s_nxt.nbytes = nb[10:0];
                  if (nb == 17'd0 || nb > 17'(`MAX_DATA)) begin
                    s_nxt.err = `ERR_LEN;
                  end else if (nb > 17'(`SHORT_MAX) && (s_r.ntype != `TYPE_BUF
                               || {1'b0, s_r.nlen} != nb + 17'(`BUF_OVH))) begin
                    s_nxt.err = `ERR_REQ;
                  end
                  if (s_nxt.err != `ERR_NONE) begin
                    s_nxt.nbytes = 11'd0;
                    s_nxt.st = bc ? serial_table_access_pkg::ST_IDLE
                             : serial_table_access_pkg::ST_TX;
                  end else if (nb <= 17'(`SHORT_MAX)) begin
                    s_nxt.tidx = 11'd0;
                    s_nxt.st = serial_table_access_pkg::ST_COMMIT;
                  end else if (bc) begin
                    s_nxt.st = serial_table_access_pkg::ST_BUF;
                  end else begin
                    s_nxt.kind = serial_table_access_pkg::TX_INTERM;
                    s_nxt.st = serial_table_access_pkg::ST_TX;
                  end
                end else if (s_r.session && !bc) begin
                  s_nxt.err = `ERR_REQ;
                  s_nxt.nbytes = 11'd0;
                  s_nxt.st = serial_table_access_pkg::ST_TX;
                end
              end
            end
          end
        end
        serial_table_access_pkg::ST_COMMIT: begin
          s_nxt.tbl.en = 1'b1;
          s_nxt.tbl.we = 1'b1;
          s_nxt.tbl.seg = s_r.seg;
          s_nxt.tbl.offset = s_r.off;
          s_nxt.tbl.index = s_r.tidx[9:0];
          s_nxt.tbl.wdata = (s_r.nbytes > `SHORT_MAX) ? wbuf[s_r.tidx[9:0]]
                          : (s_r.tidx == 11'd0) ? s_r.d0 : s_r.d1;
          s_nxt.tidx = s_r.tidx + 11'd1;
          if (s_r.tidx == s_r.nbytes - 11'd1) begin
            s_nxt.tidx = 11'd1;
            s_nxt.tacc = `ZERO_BYTE;
            s_nxt.nbytes = 11'd0;
            s_nxt.kind = serial_table_access_pkg::TX_RESP;
            s_nxt.st = s_r.bcast ? serial_table_access_pkg::ST_IDLE
                     : serial_table_access_pkg::ST_TX;
          end
        end
        serial_table_access_pkg::ST_TX: begin
          if (s_r.tidx == total) pbyte = s_r.tacc;
          else if (s_r.tidx == `P_SOM) pbyte = `SOM;
          else if (s_r.tidx == `P_TYPE) pbyte = `TYPE_REQ;
          else if (s_r.tidx == eobp) pbyte = `EOB;
          else if (s_r.kind == serial_table_access_pkg::TX_ATTACH) begin
            if (s_r.tidx <= `P_ID_HI) pbyte = own_id[{sh, 3'b000} +: 8];
            else if (s_r.tidx == `P_CODE) pbyte = s_r.code | `RESP_BIT;
          end else if (in_data) pbyte = tbl_rdata;
          else if (s_r.tidx == `R_CODE) pbyte = s_r.code | `RESP_BIT;
          else if (s_r.tidx == `R_STW0) pbyte = ctl_status[7:0];
          else if (s_r.tidx == `R_STW1) pbyte = ctl_status[15:8];
          else if (s_r.tidx == `R_MAJ) pbyte = s_r.err;
          else if (s_r.tidx == `R_CNT0) pbyte = cnt[7:0];
          else if (s_r.tidx == `R_CNT1) pbyte = {5'h00, cnt[10:8]};
          if (in_data && !s_r.rd_wait) begin
            s_nxt.tbl.en = 1'b1;
            s_nxt.tbl.we = 1'b0;
            s_nxt.tbl.seg = s_r.seg;
            s_nxt.tbl.offset = s_r.off;
            s_nxt.tbl.index = 10'(s_r.tidx - `RESP_HDR - 11'd1);
            s_nxt.rd_wait = 1'b1;
          end else if (in_data && !fifo_ready) begin
            s_nxt.tbl = s_r.tbl;
          end else if (fifo_ready) begin
            push = 1'b1;
            s_nxt.rd_wait = 1'b0;
            s_nxt.tacc = tacc_o;
            s_nxt.tidx = s_r.tidx + 11'd1;
            if (s_r.tidx == total) begin
              s_nxt.ridx = 11'd0;
              s_nxt.st = (s_r.kind == serial_table_access_pkg::TX_INTERM)
                       ? serial_table_access_pkg::ST_BUF : serial_table_access_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wb_we) begin
      wbuf[wb_addr] <= rx_data;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_no_bcast_tx;
    s_r.st == serial_table_access_pkg::ST_TX |-> !s_r.bcast;
  endproperty
  a_no_bcast_tx: assert property (p_no_bcast_tx) else $error("reply to broadcast");
  property p_bcast_attach;
    rx_valid && last && chk_ok && !s_r.bad && bc && s_r.code == `REQ_ATTACH
      && s_r.st == serial_table_access_pkg::ST_IDLE && !long_break
      |=> s_r.st == serial_table_access_pkg::ST_IDLE && s_r.session;
  endproperty
  a_bcast_attach: assert property (p_bcast_attach) else $error("broadcast attach answered");
  property p_resp_code;
    push && s_r.tidx == `R_CODE && s_r.kind != serial_table_access_pkg::TX_ATTACH
      |-> pbyte == (s_r.code | `RESP_BIT) && pbyte[7];
  endproperty
  a_resp_code: assert property (p_resp_code) else $error("bad response code");
  property p_read_max;
    s_r.st == serial_table_access_pkg::ST_TX |-> s_r.nbytes <= `MAX_DATA;
  endproperty
  a_read_max: assert property (p_read_max) else $error("reply too long");
  property p_bad_check;
    rx_valid && last && !chk_ok && !long_break |=> s_r.st == serial_table_access_pkg::ST_IDLE;
  endproperty
  a_bad_check: assert property (p_bad_check) else $error("bad check frame kept");
  property p_eob_byte;
    push && s_r.tidx == eobp |-> pbyte == `EOB && !in_data;
  endproperty
  a_eob_byte: assert property (p_eob_byte) else $error("end of block misplaced");
  property p_check_last;
    push && s_r.tidx == total |-> pbyte == s_r.tacc ##1 s_r.st != serial_table_access_pkg::ST_TX;
  endproperty
  a_check_last: assert property (p_check_last) else $error("check byte wrong");
  property p_interm_then_buf;
    push && s_r.tidx == total && s_r.kind == serial_table_access_pkg::TX_INTERM && !long_break
      |=> s_r.st == serial_table_access_pkg::ST_BUF && s_r.ridx == 11'd0;
  endproperty
  a_interm_then_buf: assert property (p_interm_then_buf) else $error("no buffer wait");
  property p_err_no_data;
    s_r.st == serial_table_access_pkg::ST_TX && s_r.err != `ERR_NONE |-> s_r.nbytes == 11'd0;
  endproperty
  a_err_no_data: assert property (p_err_no_data) else $error("error reply carries data");
  property p_commit_bound;
    s_r.st == serial_table_access_pkg::ST_COMMIT && !long_break
      |-> s_r.tidx < `MAX_DATA ##1 tbl_req.we;
  endproperty
  a_commit_bound: assert property (p_commit_bound) else $error("write past limit");
  c_read: cover property (push && s_r.tidx == `R_CODE && s_r.code == `REQ_READ);
  c_attach: cover property (push && s_r.kind == serial_table_access_pkg::TX_ATTACH);
  c_interm: cover property (s_r.st == serial_table_access_pkg::ST_BUF ##[1:200] tbl_req.we);
endmodule
`default_nettype wire

/* File: serial_table_access_slave_test.sv */
// self-checking bench for the table access slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin num_errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
module serial_table_access_slave_test;
  typedef logic [7:0] bytes_t[$];
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [63:0] own_id = 64'h0;
  logic p2p_mode = 1'b0;
  logic [15:0] ctl_status = 16'h0;
  logic slow = 1'b0;
  logic rx_valid, long_break, tx_valid, tx_ready, session_active;
  logic [7:0] rx_data, tx_data, tbl_rdata;
  serial_table_access_pkg::tbl_req_t tbl_req;
  logic stall = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h2EA4;
  serial_table_access_slave serial_table_access_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .own_id(own_id), .p2p_mode(p2p_mode), .ctl_status(ctl_status), .rx_valid(rx_valid),
    .rx_data(rx_data), .long_break(long_break), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tbl_req(tbl_req), .tbl_rdata(tbl_rdata),
    .session_active(session_active));
  master_model master_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .long_break(long_break), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .slow(slow), .stall(stall), .tbl_req(tbl_req), .tbl_rdata(tbl_rdata));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] bcc(input bytes_t q);
    logic [7:0] a = 8'h00;
    foreach (q[i]) a = {a[6:0], a[7]} ^ q[i];
    return a;
  endfunction
  function automatic bytes_t req(input logic [63:0] id, input logic [7:0] code, seg,
      input logic [15:0] off, len, input logic [7:0] d0, nt, input logic [15:0] nl);
    bytes_t q;
    q = {8'h1B, 8'h58};
    for (int i = 7; i >= 0; i--) q.push_back(id[i*8 +: 8]);
    q = {q, code, seg, off[7:0], off[15:8], len[7:0], len[15:8], d0, 8'h00};
    q = {q, 8'h17, nt, nl[7:0], nl[15:8], 8'h00};
    q.push_back(bcc(q));
    return q;
  endfunction
  function automatic bytes_t resp(input logic [7:0] code, maj, input logic [15:0] cnt,
      input bytes_t d);
    bytes_t q;
    q = {8'h1B, 8'h58, code, ctl_status[7:0], ctl_status[15:8], maj, 8'h00, cnt[7:0]};
    q = {q, cnt[15:8], d, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
    q.push_back(bcc(q));
    return q;
  endfunction
  function automatic bytes_t tdat(input logic [15:0] off, input int n);
    bytes_t q;
    for (int i = 0; i < n; i++) q.push_back(master_model_inst.tbyte(off, 10'(i)));
    return q;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input bytes_t f, input bytes_t e);
    int t;
    master_model_inst.rq.delete();
    master_model_inst.wq.delete();
    master_model_inst.iq.delete();
    master_model_inst.send(f);
    t = 0;
    while (master_model_inst.rq.size() < e.size() && t < 8000) begin
      @(posedge ref_clk);
      t++;
    end
    if (t >= 8000) begin
      num_errors++;
      end_sim();
    end
    repeat (60) @(posedge ref_clk);
    `CHK(master_model_inst.rq.size(), e.size())
    foreach (e[i]) if (i < master_model_inst.rq.size()) `CHK(master_model_inst.rq[i], e[i])
  endtask
  initial begin
    int sg[6] = '{8, 72, 8, 8, 8, 3};
    int ln[6] = '{4, 9, 0, 501, 500, 1001};
    int ct[6] = '{8, 2, 0, 0, 1000, 0};
    logic [63:0] bid = 64'hFFFF_FFFF_FFFF_FFFF;
    logic [63:0] id;
    logic [15:0] off;
    bytes_t b, f, e, nil;
    repeat (3) @(posedge ref_clk);
    own_id <= {8'h41, 8'h42, 16'h4344, rnd()};
    ctl_status <= 16'(rnd());
    rst_n <= 1'b1;
    master_model_inst.brk();
    xfer(req(own_id, 8'h00, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0),
      req(own_id, 8'h80, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0));
    `CHK(session_active, 1'b1)
    for (int k = 0; k < 6; k++) begin
      off = 16'(rnd());
      slow <= 1'(rnd());
      e = resp(8'h81, ct[k] != 0 ? 8'h00 : 8'h02, 16'(ct[k]), tdat(off, ct[k]));
      xfer(req(own_id, 8'h01, 8'(sg[k]), off, 16'(ln[k]), 8'h00, 8'h00, 16'h0), e);
    end
    xfer(req(bid, 8'h01, 8'h08, off, 16'h1, 8'h00, 8'h00, 16'h0), nil);
    p2p_mode <= 1'b1;
    e = resp(8'h81, 8'h00, 16'h2, tdat(off, 2));
    xfer(req(64'h0, 8'h01, 8'h00, off, 16'h2, 8'h00, 8'h00, 16'h0), e);
    p2p_mode <= 1'b0;
    xfer(req(64'h0, 8'h01, 8'h00, off, 16'h2, 8'h00, 8'h00, 16'h0), nil);
    xfer(req(own_id, 8'h05, 8'h00, off, 16'h1, 8'h00, 8'h00, 16'h0),
      resp(8'h85, 8'h01, 16'h0, nil));
    xfer(req(own_id, 8'h02, 8'h48, off, 16'h1, 8'h08, 8'h00, 16'h0),
      resp(8'h82, 8'h00, 16'h0, nil));
    `CHK(master_model_inst.wq.size(), 1)
    `CHK(master_model_inst.wq[0], 8'h08)
    `CHK(master_model_inst.iq[0], 10'h000)
    for (int k = 0; k < 3; k++) begin
      b.delete();
      repeat (4) b.push_back(8'(rnd()));
      id = k == 2 ? bid : own_id;
      e = resp(8'h82, 8'h00, 16'h0, nil);
      if (k == 2) e = nil;
      xfer(req(id, 8'h02, 8'h08, off, 16'h2, 8'h00, 8'h54, 16'h000C), e);
      f = {8'h1B, k == 1 ? 8'h55 : 8'h54, b, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
      f.push_back(bcc(f));
      e = resp(8'h82, k == 1 ? 8'h01 : 8'h00, 16'h0, nil);
      if (k == 2) e = nil;
      xfer(f, e);
      `CHK(master_model_inst.wq.size(), k == 1 ? 0 : 4)
      if (k != 1) foreach (b[i]) `CHK(master_model_inst.wq[i], b[i])
      if (k == 2) master_model_inst.bcast_wait();
    end
    f = req(own_id, 8'h01, 8'h08, off, 16'h1, 8'h00, 8'h00, 16'h0);
    f[23] = f[23] ^ 8'h01;
    xfer(f, nil);
    f[18] = 8'h16;
    f[23] = bcc(f[0:22]);
    xfer(f, nil);
    master_model_inst.brk();
    `CHK(session_active, 1'b0)
    xfer(req(own_id, 8'h01, 8'h08, off, 16'h1, 8'h00, 8'h00, 16'h0), nil);
    xfer(req(bid, 8'h00, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0), nil);
    `CHK(session_active, 1'b1)
    master_model_inst.bcast_wait();
    // stall the far side so a reply backs up in the transmit buffer, then drain it whole
    stall <= 1'b1;
    master_model_inst.rq.delete();
    master_model_inst.send(req(own_id, 8'h00, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0));
    repeat (40) @(posedge ref_clk);
    `CHK(tx_valid, 1'b1)
    `CHK(master_model_inst.rq.size(), 0)
    `CHK(tx_data, 8'h1B)
    stall <= 1'b0;
    xfer(nil, req(own_id, 8'h80, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0));
    end_sim();
  end
endmodule
`default_nettype wire
